// ### hdl/rftm_monitor_core.sv
// Rail voltage, timing and temperature supervision with alert and fault responses.
`timescale 1ns/1ps
module rftm_monitor_core
	import rftm_pkg::*;
#(
	parameter int N = NUM_RAILS,
	parameter int MON_CYCLES = MON_PERIOD_US * (CLK_HZ / 1_000_000),
	parameter int TEMP_CYCLES = TEMP_PERIOD_MS * (CLK_HZ / 1000)
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [ADC_W-1:0] railVolt [N],
	input wire logic [ADC_W-1:0] railNominal [N],
	input wire logic [ADC_W-1:0] pgOnLimit [N],
	input wire logic [ADC_W-1:0] uvWarnLimit [N],
	input wire logic [ADC_W-1:0] uvFaultLimit [N],
	input wire logic [ADC_W-1:0] ovWarnLimit [N],
	input wire logic [ADC_W-1:0] ovFaultLimit [N],
	input wire logic [TIME_W-1:0] tonMax [N],
	input wire logic [TIME_W-1:0] toffMax [N],
	input wire logic [TIME_W-1:0] toffDelay [N],
	input wire logic [N-1:0] railEnableCmd,
	input wire rftm_resp_e faultResp [N],
	input wire logic [N-1:0] slaveMask [N],
	input wire logic [N-1:0] offDepMask [N],
	input wire logic [N-1:0] glitchEn,
	input wire logic [GLITCH_W-1:0] glitchSteps [N],
	input wire logic [N-1:0] warnGpioEn,
	input wire logic [ADC_W-1:0] monitor_input [N],
	input wire logic [N-1:0] tempMonAssigned,
	input wire logic signed [TEMP_W-1:0] tempGain [N],
	input wire logic signed [TEMP_W-1:0] tempOffset [N],
	input wire logic signed [TEMP_W-1:0] linear_temp_sensor,
	input wire logic signed [TEMP_W-1:0] otWarnLimit [N],
	input wire logic signed [TEMP_W-1:0] otFaultLimit [N],
	input wire logic hostTempWr,
	input wire logic [$clog2(N)-1:0] hostTempRail,
	input wire logic signed [TEMP_W-1:0] hostTempData,
	input wire logic statusClr,
	input wire logic [$clog2(N)-1:0] statusClrRail,
	input wire logic [ST_W-1:0] statusClrMask,
	output logic alert_out_n,
	output logic [ST_W-1:0] statusBits [N],
	output logic [N-1:0] railEnable,
	output logic [N-1:0] warnGpio,
	output logic signed [TEMP_W-1:0] railTemp [N],
	output logic signed [TEMP_W-1:0] peakTemp [N],
	output logic faultLogValid,
	output logic [$clog2(N)-1:0] faultLogRail,
	output logic [ST_W-1:0] faultLogCode
);
	localparam int IW = $clog2(N);
	localparam int MCW = $clog2(MON_CYCLES);
	localparam int TCW = $clog2(TEMP_CYCLES);
	localparam int PW = ADC_W + TEMP_W + 1;
	localparam logic [TIME_W-1:0] TIME_SAT = {TIME_W{1'b1}};

	rftm_eval_e evState_r;
	logic [IW-1:0] idx_r;
	logic [MCW-1:0] monCnt_r;
	logic [TCW-1:0] tempCnt_r;
	logic [IW-1:0] tempRail_r;
	logic monTick;
	logic tempTick;
	logic scanning;
	logic [N-1:0] hit;
	logic [N-1:0] immHit;
	logic [N-1:0] railLow;
	logic [N-1:0] logReq;
	logic [N-1:0] stAny;
	logic [ST_W-1:0] logCode [N];

	assign monTick = (monCnt_r == MCW'(MON_CYCLES - 1));
	assign tempTick = (tempCnt_r == TCW'(TEMP_CYCLES - 1));
	assign scanning = (evState_r == EV_SCAN);

	// Monitoring cycle timer, free-running from reset
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			monCnt_r <= '0;
		end else if (monTick) begin
			monCnt_r <= '0;
		end else begin
			monCnt_r <= monCnt_r + MCW'(1);
		end
	end

	// Temperature slot timer; no power-good gating [RULE_03]
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tempCnt_r <= '0;
			tempRail_r <= '0;
		end else if (tempTick) begin
			tempCnt_r <= '0;
			tempRail_r <= (tempRail_r == IW'(N - 1)) ? '0 : tempRail_r + IW'(1); // [RULE_02]
		end else begin
			tempCnt_r <= tempCnt_r + TCW'(1);
		end
	end

	// One rail per clock, index order, once per monitoring cycle [RULE_12] [RULE_21] [RULE_23]
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			evState_r <= EV_IDLE;
			idx_r <= '0;
		end else begin
			case (evState_r)
				EV_IDLE: begin
					idx_r <= '0;
					if (monTick) begin
						evState_r <= EV_SCAN;
					end
				end
				EV_SCAN: begin
					if (idx_r == IW'(N - 1)) begin
						evState_r <= EV_IDLE;
						idx_r <= '0;
					end else begin
						idx_r <= idx_r + IW'(1);
					end
				end
				default: begin
					evState_r <= EV_IDLE;
					idx_r <= '0;
				end
			endcase
		end
	end

	generate
		for (genvar i = 0; i < N; i++) begin : g_rail
			logic tick;
			logic en_r;
			logic pgSeen_r;
			logic wasOn_r;
			logic [TIME_W-1:0] tonCnt_r;
			logic [TIME_W-1:0] offCnt_r;
			logic [TIME_W-1:0] dly_r;
			logic faultOff_r;
			logic pend_r;
			logic sched;
			logic depsOff;
			logic [ST_W-1:0] st_r;
			logic [ST_W-1:0] raw;
			logic [ST_W-1:0] clrMask;
			logic [ST_W-1:0] st_nxt;
			logic hostOvr_r;
			logic signed [TEMP_W-1:0] hostTemp_r;
			logic signed [PW-1:0] prod;
			logic signed [TEMP_W-1:0] calcTemp;
			logic signed [TEMP_W-1:0] avgTemp;
			logic signed [TEMP_W-1:0] effTemp;
			logic sampleValid;

			assign tick = scanning & (idx_r == IW'(i));
			assign railLow[i] = (railVolt[i] <= (railNominal[i] >> TOFF_SHIFT)); // [RULE_16]

			// Remote temperature from monitor voltage, gain and zero-volt offset [RULE_04]
			assign prod = $signed({1'b0, monitor_input[i]}) * tempGain[i];
			assign calcTemp = tempOffset[i] + TEMP_W'(prod >>> GAIN_FRAC);
			// Sampling stops for good once the host has supplied this rail [RULE_06]
			assign sampleValid = tempTick & (tempRail_r == IW'(i)) & tempMonAssigned[i] & ~hostOvr_r;

			rftm_temp_avg #(
				.W(TEMP_W),
				.DEPTH(AVG_DEPTH)
			) u_avg (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.sampleValid(sampleValid),
				.sample(calcTemp),
				.avg(avgTemp)
			);

			// Host value wins; unassigned rails fall back to the internal sensor [RULE_05] [RULE_07]
			always_comb begin
				if (hostOvr_r) begin
					effTemp = hostTemp_r;
				end else if (tempMonAssigned[i]) begin
					effTemp = avgTemp;
				end else begin
					effTemp = linear_temp_sensor;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					hostOvr_r <= 1'b0;
					hostTemp_r <= '0;
				end else if (hostTempWr && hostTempRail == IW'(i)) begin
					hostOvr_r <= 1'b1; // [RULE_06]
					hostTemp_r <= hostTempData; // [RULE_05]
				end
			end

			// Reported and peak temperature use the same source as the checks [RULE_08]
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					railTemp[i] <= '0;
					peakTemp[i] <= {1'b1, {(TEMP_W - 1){1'b0}}};
				end else begin
					railTemp[i] <= effTemp;
					if (effTemp > peakTemp[i]) begin
						peakTemp[i] <= effTemp; // [RULE_08]
					end
				end
			end

			// Power-good reached latch and turn-on timer, counted in monitoring cycles
			always_ff @(posedge sys_clk) begin
				if (!resetn || !en_r) begin
					pgSeen_r <= 1'b0;
					tonCnt_r <= '0;
				end else if (tick) begin
					if (railVolt[i] >= pgOnLimit[i]) begin
						pgSeen_r <= 1'b1;
					end
					if (!pgSeen_r && tonCnt_r != TIME_SAT) begin
						tonCnt_r <= tonCnt_r + TIME_W'(1);
					end
				end
			end

			// Turn-off timer only after the rail was on, so rails never started stay quiet
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					wasOn_r <= 1'b0;
					offCnt_r <= '0;
				end else if (en_r) begin
					wasOn_r <= 1'b1;
					offCnt_r <= '0;
				end else if (tick) begin
					if (railLow[i]) begin
						wasOn_r <= 1'b0;
					end else if (offCnt_r != TIME_SAT) begin
						offCnt_r <= offCnt_r + TIME_W'(1);
					end
				end
			end

			always_comb begin
				raw = '0;
				raw[ST_UV_WARN] = pgSeen_r & (railVolt[i] < uvWarnLimit[i]); // [RULE_14]
				raw[ST_UV_FAULT] = pgSeen_r & (railVolt[i] < uvFaultLimit[i]); // [RULE_14]
				raw[ST_OV_WARN] = railVolt[i] > ovWarnLimit[i]; // [RULE_15]
				raw[ST_OV_FAULT] = railVolt[i] > ovFaultLimit[i]; // [RULE_15]
				raw[ST_TON_FAULT] = en_r & ~pgSeen_r & (tonCnt_r >= tonMax[i]); // [RULE_13]
				raw[ST_TOFF_WARN] = ~en_r & wasOn_r & ~railLow[i] & (offCnt_r >= toffMax[i]); // [RULE_16]
				raw[ST_OT_WARN] = effTemp > otWarnLimit[i]; // [RULE_08]
				raw[ST_OT_FAULT] = effTemp > otFaultLimit[i]; // [RULE_08]
			end

			// A violation seen in the clear cycle survives: set wins over clear [RULE_22]
			assign clrMask = (statusClr && statusClrRail == IW'(i)) ? statusClrMask : ST_RESET;
			assign st_nxt = (st_r & ~clrMask) | (tick ? raw : ST_RESET); // [RULE_09]
			assign stAny[i] = |st_nxt;
			assign statusBits[i] = st_r;

			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					st_r <= ST_RESET;
					warnGpio[i] <= 1'b0;
				end else begin
					st_r <= st_nxt;
					warnGpio[i] <= warnGpioEn[i] & |(st_nxt & ST_WARN_MASK); // [RULE_17]
				end
			end

			// Log new faults before filtering; warnings never reach the log [RULE_11] [RULE_17]
			assign logReq[i] = tick & |(raw & ~st_r & ST_FAULT_MASK);
			assign logCode[i] = raw & ST_FAULT_MASK;

			rftm_glitch_filter #(
				.W(GLITCH_W)
			) u_glitch (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.tick(tick),
				.cond(|(raw & ST_FAULT_MASK)),
				.filtEn(glitchEn[i]),
				.steps(glitchSteps[i]),
				.pass(hit[i])
			);

			// Continue selects nothing here beyond the status flag [RULE_18]
			assign immHit[i] = hit[i] & (faultResp[i] == RESP_IMMEDIATE); // [RULE_19]

			always_comb begin
				sched = 1'b0;
				for (int j = 0; j < N; j++) begin
					if (hit[j] && faultResp[j] == RESP_DELAYED && (j == i || slaveMask[j][i])) begin
						sched = 1'b1; // [RULE_20]
					end
				end
			end

			assign depsOff = &(~offDepMask[i] | railLow);

			// Delayed shutdown waits for off-dependencies, then its own turn-off delay
			always_ff @(posedge sys_clk) begin
				if (!resetn || !railEnableCmd[i]) begin
					pend_r <= 1'b0;
					dly_r <= '0;
					faultOff_r <= 1'b0;
				end else begin
					if (immHit[i]) begin
						faultOff_r <= 1'b1; // [RULE_19]
						pend_r <= 1'b0;
					end else if (sched && !faultOff_r && !pend_r) begin
						// A repeated hit on the own scan must not starve the countdown below
						pend_r <= 1'b1; // [RULE_20]
					end else if (pend_r && tick && depsOff) begin
						if (dly_r >= toffDelay[i]) begin
							faultOff_r <= 1'b1; // [RULE_20]
							pend_r <= 1'b0;
						end else begin
							dly_r <= dly_r + TIME_W'(1);
						end
					end
				end
			end

			// Enable drops on the same edge that takes the immediate fault [RULE_19]
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					en_r <= 1'b0;
				end else begin
					en_r <= railEnableCmd[i] & ~faultOff_r & ~immHit[i];
				end
			end
			assign railEnable[i] = en_r;
		end
	endgenerate

	// Alert tracks the sticky status, asserted on the edge the bit is set [RULE_09] [RULE_22]
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			alert_out_n <= 1'b1;
		end else begin
			alert_out_n <= ~|stAny;
		end
	end

	// Only the scanned rail can request, so no arbitration is needed [RULE_23]
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			faultLogValid <= 1'b0;
			faultLogRail <= '0;
			faultLogCode <= ST_RESET;
		end else begin
			faultLogValid <= |logReq; // [RULE_11]
			if (|logReq) begin
				faultLogRail <= idx_r;
				faultLogCode <= logCode[idx_r];
			end
		end
	end
endmodule // rftm_monitor_core

// ### hdl/rftm_pkg.sv
// Constants, types and encodings shared by the rail fault and temperature monitor.
// How it works
// RULE_01 - Temperature inputs report a sliding average of their last sixteen samples.
// RULE_02 - One rail temperature is sampled every 100 ms in rotation.
// RULE_03 - Temperature supervision starts right after reset, not gated by power-good.
// RULE_04 - Remote temperature is offset plus monitor voltage times gain.
// RULE_05 - A host-written rail temperature is used until the host writes again.
// RULE_06 - Once the host writes, that rail's monitor input is not sampled until reset.
// RULE_07 - Rails without monitor input use the internal sensor until the host writes.
// RULE_08 - Host temperatures feed over-temperature checks, peak logging and logic flags.
// RULE_09 - Any window violation sets status bits and asserts the alert at once.
// RULE_10 - Per-input switchable glitch filter, 0 to 102 ms in 400 us steps.
// RULE_11 - Glitch filter delays only the response; the fault is still logged.
// RULE_12 - Stored ADC results are stepped through and compared with their limits.
// RULE_13 - Turn-on fault when an enabled rail misses power-good within its time.
// RULE_14 - Undervoltage checks only after the rail has reached power-good.
// RULE_15 - Overvoltage checks run always, during startup and operation.
// RULE_16 - Turn-off warning when a rail stays above 12.5% nominal too long.
// RULE_17 - Warnings assert alert, set status, drive an optional pin; never logged.
// RULE_18 - Continue response only flags the fault.
// RULE_19 - Immediate response drops the rail enable without delay.
// RULE_20 - Delayed response turns off rail and slaves by dependencies and delays.
// RULE_21 - Every rail is evaluated once in each 400 us cycle.
// RULE_22 - Alert stays asserted until the host clears the status bits.
// RULE_23 - Rails are evaluated in fixed index order.
package rftm_pkg;
	localparam int NUM_RAILS = 10;
	localparam int ADC_W = 12;
	localparam int TEMP_W = 16;
	localparam int TIME_W = 10;
	localparam int GAIN_FRAC = 8;
	localparam int AVG_DEPTH = 16;
	localparam int CLK_HZ = 20_000_000;
	localparam int MON_PERIOD_US = 400;
	localparam int TEMP_PERIOD_MS = 100;
	localparam int GLITCH_STEP_US = 400;
	localparam int GLITCH_MAX_MS = 102;
	localparam int GLITCH_MAX_STEPS = GLITCH_MAX_MS * 1000 / GLITCH_STEP_US;
	localparam int GLITCH_W = $clog2(GLITCH_MAX_STEPS + 1);
	localparam int TOFF_SHIFT = 3;
	localparam int ST_W = 8;
	localparam int ST_UV_WARN = 0;
	localparam int ST_UV_FAULT = 1;
	localparam int ST_OV_WARN = 2;
	localparam int ST_OV_FAULT = 3;
	localparam int ST_TON_FAULT = 4;
	localparam int ST_TOFF_WARN = 5;
	localparam int ST_OT_WARN = 6;
	localparam int ST_OT_FAULT = 7;
	localparam logic [ST_W-1:0] ST_WARN_MASK = 8'h65;
	localparam logic [ST_W-1:0] ST_FAULT_MASK = 8'h9a;
	localparam logic [ST_W-1:0] ST_RESET = 8'h00;
	typedef enum logic [1:0] {
		RESP_CONTINUE = 2'h0,
		RESP_IMMEDIATE = 2'h1,
		RESP_DELAYED = 2'h2
	} rftm_resp_e;
	typedef enum logic [1:0] {
		EV_IDLE = 2'h0,
		EV_SCAN = 2'h1
	} rftm_eval_e;
endpackage

// ### hdl/rftm_glitch_filter.sv
// Per-input glitch filter counting consecutive violating evaluations.
`timescale 1ns/1ps
module rftm_glitch_filter
	import rftm_pkg::*;
#(
	parameter int W = GLITCH_W
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic cond,
	input wire logic filtEn,
	input wire logic [W-1:0] steps,
	output logic pass
);
	logic [W-1:0] cnt_r;

	// Response passes once the condition has lasted steps + 1 evaluations [RULE_10]
	assign pass = tick & cond & (~filtEn | (cnt_r >= steps));

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else if (tick) begin
			if (!cond) begin
				cnt_r <= '0;
			end else if (cnt_r != {W{1'b1}}) begin
				cnt_r <= cnt_r + W'(1);
			end
		end
	end
endmodule // rftm_glitch_filter

// ### hdl/rftm_temp_avg.sv
// Sliding-window average of the most recent temperature samples.
`timescale 1ns/1ps
module rftm_temp_avg
	import rftm_pkg::*;
#(
	parameter int W = TEMP_W,
	parameter int DEPTH = AVG_DEPTH
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic sampleValid,
	input wire logic signed [W-1:0] sample,
	output logic signed [W-1:0] avg
);
	localparam int LG = $clog2(DEPTH);
	localparam int SW = W + LG;
	logic signed [W-1:0] win_r [DEPTH];
	logic [LG-1:0] ptr_r;
	logic signed [SW-1:0] sum_r;
	logic signed [SW-1:0] sum_nxt;

	// Running sum drops the oldest sample; window starts filled with zeros
	assign sum_nxt = sum_r + SW'(sample) - SW'(win_r[ptr_r]);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ptr_r <= '0;
			sum_r <= '0;
			avg <= '0;
			for (int k = 0; k < DEPTH; k++) begin
				win_r[k] <= '0;
			end
		end else if (sampleValid) begin
			win_r[ptr_r] <= sample;
			ptr_r <= ptr_r + LG'(1);
			sum_r <= sum_nxt;
			avg <= W'(sum_nxt >>> LG); // [RULE_01]
		end
	end
endmodule // rftm_temp_avg

// ### dv/rftm_rail_model.sv
// Behavioural rails: each ramps toward its set level while enabled and decays when off.
`timescale 1ns/1ps
module rftm_rail_model
	import rftm_pkg::*;
#(
	parameter int N = NUM_RAILS,
	parameter logic [ADC_W-1:0] STEP = 12'h010
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [N-1:0] railEnable,
	input wire logic [ADC_W-1:0] setLevel [N],
	output logic [ADC_W-1:0] railVolt [N]
);
	// Finite slew both ways, so turn-on and turn-off timing really runs
	always @(posedge sys_clk) begin
		for (int i = 0; i < N; i++) begin
			if (!resetn)
				railVolt[i] <= '0;
			else if (railEnable[i] && railVolt[i] < setLevel[i])
				railVolt[i] <= (setLevel[i] - railVolt[i] > STEP) ? railVolt[i] + STEP : setLevel[i];
			else if (railEnable[i])
				railVolt[i] <= (railVolt[i] - setLevel[i] > STEP) ? railVolt[i] - STEP : setLevel[i];
			else
				railVolt[i] <= (railVolt[i] > STEP) ? railVolt[i] - STEP : '0;
		end
	end
endmodule // rftm_rail_model

// ### dv/rftm_monitor_checker.sv
// Port-level assertions for the monitor core, bound to its top module.
`timescale 1ns/1ps
module rftm_monitor_checker
	import rftm_pkg::*;
#(
	parameter int N = NUM_RAILS,
	parameter int MON_CYCLES = 8000,
	parameter int TEMP_CYCLES = 2000000
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [ADC_W-1:0] railVolt [N],
	input wire logic [ADC_W-1:0] pgOnLimit [N],
	input wire logic [N-1:0] railEnableCmd,
	input wire rftm_resp_e faultResp [N],
	input wire logic [N-1:0] glitchEn,
	input wire logic [N-1:0] warnGpioEn,
	input wire logic statusClr,
	input wire logic [$clog2(N)-1:0] statusClrRail,
	input wire logic [ST_W-1:0] statusClrMask,
	input wire logic alert_out_n,
	input wire logic [ST_W-1:0] statusBits [N],
	input wire logic [N-1:0] railEnable,
	input wire logic [N-1:0] warnGpio,
	input wire logic faultLogValid,
	input wire logic [ST_W-1:0] faultLogCode
);
	logic [ST_W-1:0] prevStat_r [N];
	logic [N-1:0] pgSeen_r, newAny, newFlt, lost, slotBad, uvBad;
	logic anyStat, clrPrev_r;
	logic [$clog2(N)-1:0] clrRail_r;
	logic [ST_W-1:0] clrMask_r;
	int cyc_r;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	always_ff @(posedge sys_clk) begin
		prevStat_r <= statusBits;
		clrPrev_r <= statusClr;
		clrRail_r <= statusClrRail;
		clrMask_r <= statusClrMask;
		cyc_r <= resetn ? cyc_r + 1 : 0;
	end
	// Looser than the core's tracker on purpose, so it can never lag it
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < N; i++) begin
			if (!resetn || !(railEnable[i] || railEnableCmd[i]))
				pgSeen_r[i] <= 1'b0;
			else if (railVolt[i] >= pgOnLimit[i])
				pgSeen_r[i] <= 1'b1;
		end
	end
	always_comb begin
		anyStat = 1'b0;
		for (int i = 0; i < N; i++) begin
			anyStat = anyStat | (|statusBits[i]);
			newAny[i] = |(statusBits[i] & ~prevStat_r[i]);
			newFlt[i] = |(statusBits[i] & ~prevStat_r[i] & ST_FAULT_MASK);
			uvBad[i] = |(statusBits[i] & ~prevStat_r[i] & 8'h03) && !pgSeen_r[i];
			lost[i] = |(prevStat_r[i] & ~statusBits[i] & ~((clrPrev_r && clrRail_r == i) ? clrMask_r : 8'h00));
			slotBad[i] = |(statusBits[i] & ~prevStat_r[i] & 8'h3f)
				&& (((cyc_r - i + MON_CYCLES) % MON_CYCLES) inside {[3:MON_CYCLES-2]});
		end
	end

	chk_alert_low: assert property (anyStat |-> !alert_out_n)
		else $error("status set but alert released");
	chk_alert_fall: assert property ($fell(alert_out_n) |-> newAny != '0)
		else $error("alert fell with no new status");
	chk_alert_rise: assert property ($rose(alert_out_n) |-> $past(statusClr))
		else $error("alert released without a clear");
	chk_status_hold: assert property (lost == '0)
		else $error("status bit dropped without a clear");
	chk_scan_slot: assert property (slotBad == '0)
		else $error("status set outside its scan slot");
	chk_uv_gate: assert property (uvBad == '0)
		else $error("undervoltage flagged before power-good");
	chk_log_code: assert property (faultLogValid |-> faultLogCode != '0 && (faultLogCode & ~ST_FAULT_MASK) == '0)
		else $error("bad fault log code");
	chk_gpio_en: assert property ((warnGpio & ~(warnGpioEn | $past(warnGpioEn))) == '0)
		else $error("warning pin driven while disabled");
	chk_en_cmd: assert property ((railEnable & ~$past(railEnableCmd)) == '0)
		else $error("rail enabled without a request");
	for (genvar i = 0; i < N; i++) begin : g_imm
		chk_imm_off: assert property (newFlt[i] && faultResp[i] == RESP_IMMEDIATE && !glitchEn[i] |-> !railEnable[i])
			else $error("immediate response left rail on");
	end
	cover property ($fell(alert_out_n));
	cover property (faultLogValid && faultLogCode[ST_OV_FAULT]);
	cover property ($rose(alert_out_n));
endmodule // rftm_monitor_checker

bind rftm_monitor_core rftm_monitor_checker #(.N(N), .MON_CYCLES(MON_CYCLES), .TEMP_CYCLES(TEMP_CYCLES)) u_chk (
	.sys_clk, .resetn, .railVolt, .pgOnLimit, .railEnableCmd, .faultResp, .glitchEn, .warnGpioEn,
	.statusClr, .statusClrRail, .statusClrMask, .alert_out_n, .statusBits, .railEnable, .warnGpio,
	.faultLogValid, .faultLogCode
);

// ### dv/rftm_monitor_core_bench.sv
// Self-checking bench for the monitor core with a rail model on its far side.
`timescale 1ns/1ps
module rftm_monitor_core_bench
	import rftm_pkg::*;
;
	localparam int N = NUM_RAILS;
	localparam int MC = 16;
	logic sys_clk, resetn, hostTempWr, statusClr, alert_out_n, faultLogValid;
	logic [ADC_W-1:0] railVolt [N], railNominal [N], pgOnLimit [N], uvWarnLimit [N], uvFaultLimit [N];
	logic [ADC_W-1:0] ovWarnLimit [N], ovFaultLimit [N], monitor_input [N], setLevel [N];
	logic [TIME_W-1:0] tonMax [N], toffMax [N], toffDelay [N];
	logic [N-1:0] railEnableCmd, glitchEn, warnGpioEn, tempMonAssigned, railEnable, warnGpio;
	logic [N-1:0] slaveMask [N], offDepMask [N];
	rftm_resp_e faultResp [N];
	logic [GLITCH_W-1:0] glitchSteps [N];
	logic signed [TEMP_W-1:0] tempGain [N], tempOffset [N], otWarnLimit [N], otFaultLimit [N];
	logic signed [TEMP_W-1:0] railTemp [N], peakTemp [N], linear_temp_sensor, hostTempData, hostVal;
	logic [3:0] hostTempRail, statusClrRail, faultLogRail;
	logic [ST_W-1:0] statusClrMask, faultLogCode, statusBits [N];
	int miscompares, n_checks;

	rftm_monitor_core #(.MON_CYCLES(MC), .TEMP_CYCLES(64)) dut (
		.sys_clk, .resetn, .railVolt, .railNominal, .pgOnLimit, .uvWarnLimit, .uvFaultLimit, .ovWarnLimit,
		.ovFaultLimit, .tonMax, .toffMax, .toffDelay, .railEnableCmd, .faultResp, .slaveMask, .offDepMask,
		.glitchEn, .glitchSteps, .warnGpioEn, .monitor_input, .tempMonAssigned, .tempGain, .tempOffset,
		.linear_temp_sensor, .otWarnLimit, .otFaultLimit, .hostTempWr, .hostTempRail, .hostTempData,
		.statusClr, .statusClrRail, .statusClrMask, .alert_out_n, .statusBits, .railEnable, .warnGpio,
		.railTemp, .peakTemp, .faultLogValid, .faultLogRail, .faultLogCode
	);
	rftm_rail_model u_rails (.sys_clk, .resetn, .railEnable, .setLevel, .railVolt);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wait_bits(input int r, input logic [ST_W-1:0] m);
		int k;
		for (k = 0; k < 4000 && (statusBits[r] & m) !== m; k++)
			cyc(1);
		if (k == 4000) begin
			chk("status wait", 16'(m), 16'(statusBits[r]));
			wrap_up();
		end
	endtask
	task automatic host_write(input int r, input logic signed [TEMP_W-1:0] t);
		hostTempRail = 4'(r);
		hostTempData = t;
		hostTempWr = 1'b1;
		cyc(1);
		hostTempWr = 1'b0;
		cyc(3);
	endtask
	task automatic clear_rail(input int r);
		statusClrRail = 4'(r);
		statusClrMask = 8'hff;
		statusClr = 1'b1;
		cyc(1);
		statusClr = 1'b0;
		cyc(1);
	endtask
	// Gain carries 8 fractional bits; the bench keeps it a whole number so the product is exact
	function automatic logic [15:0] temp_of(input int r);
		return 16'(int'(monitor_input[r]) * int'(tempGain[r]) / 256 + int'(tempOffset[r]));
	endfunction

	initial begin
		void'($urandom(80));
		resetn = 1'b0;
		hostTempWr = 1'b0;
		statusClr = 1'b0;
		statusClrRail = 4'h0;
		statusClrMask = 8'h00;
		hostTempRail = 4'h0;
		hostTempData = 16'sh0000;
		linear_temp_sensor = 16'($urandom_range(0, 16'h3000));
		railEnableCmd = '0;
		glitchEn = 10'h100;
		warnGpioEn = N'($urandom);
		tempMonAssigned = 10'h104;
		railNominal = '{default: 12'h800};
		pgOnLimit = '{default: 12'h700};
		uvWarnLimit = '{default: 12'h680};
		uvFaultLimit = '{default: 12'h600};
		ovWarnLimit = '{default: 12'h900};
		ovFaultLimit = '{default: 12'ha00};
		setLevel = '{default: 12'h800};
		tonMax = '{default: 10'h3ff};
		toffMax = '{default: 10'h3ff};
		toffDelay = '{default: 10'h000};
		faultResp = '{default: RESP_CONTINUE};
		slaveMask = '{default: 10'h000};
		offDepMask = '{default: 10'h000};
		glitchSteps = '{default: 8'h00};
		otWarnLimit = '{default: 16'sh5000};
		otFaultLimit = '{default: 16'sh6000};
		for (int i = 0; i < N; i++) begin
			monitor_input[i] = 12'($urandom);
			tempGain[i] = 16'($urandom_range(1, 4) << 8);
			tempOffset[i] = 16'($urandom_range(0, 255));
		end
		faultResp[0] = RESP_IMMEDIATE;
		faultResp[2] = RESP_DELAYED;
		faultResp[8] = RESP_IMMEDIATE;
		glitchSteps[8] = 8'h03;
		slaveMask[2] = 10'h008;
		setLevel[4] = 12'h500;
		setLevel[7] = 12'h300;
		tonMax[7] = 10'h004;
		toffMax[9] = 10'h001;
		cyc(5);
		chk("reset alert", 16'h0001, 16'(alert_out_n));
		chk("reset peak", 16'h8000, peakTemp[0]);
		resetn = 1'b1;
		railEnableCmd = '1;
		cyc(12 * MC);
		chk("uv before pg", 16'h0000, 16'(statusBits[4]));
		wait_bits(7, 8'h10);
		chk("continue ton", 16'h0001, 16'(railEnable[7]));
		chk("alert", 16'h0000, 16'(alert_out_n));
		railEnableCmd[9] = 1'b0;
		wait_bits(9, 8'h20);
		setLevel[0] = 12'ha80;
		wait_bits(0, 8'h0c);
		chk("immediate off", 16'h0000, 16'(railEnable[0]));
		setLevel[1] = 12'ha80;
		wait_bits(1, 8'h0c);
		chk("continue on", 16'h0001, 16'(railEnable[1]));
		setLevel[5] = 12'h950;
		wait_bits(5, 8'h04);
		cyc(3 * MC);
		chk("warn only", 16'h0004, 16'(statusBits[5]));
		chk("warn pin", 16'(warnGpioEn[5]), 16'(warnGpio[5]));
		setLevel[6] = 12'h650;
		wait_bits(6, 8'h01);
		chk("uv warn", 16'h0001, 16'(statusBits[6]));
		setLevel[2] = 12'ha80;
		wait_bits(2, 8'h08);
		chk("delayed not yet", 16'h0001, 16'(railEnable[2]));
		cyc(3 * MC);
		chk("delayed with slave", 16'h0000, 16'(railEnable[3:2]));
		setLevel[8] = 12'ha80;
		wait_bits(8, 8'h08);
		chk("log valid", 16'h0001, 16'(faultLogValid));
		chk("log rail", 16'h0008, 16'(faultLogRail));
		chk("log code", 16'h0008, 16'(faultLogCode));
		cyc(2 * MC);
		chk("glitch held", 16'h0001, 16'(railEnable[8]));
		cyc(2 * MC);
		chk("glitch off", 16'h0000, 16'(railEnable[8]));
		setLevel[5] = 12'h800;
		cyc(3 * MC);
		clear_rail(5);
		chk("cleared", 16'h0000, 16'(statusBits[5]));
		chk("alert held", 16'h0000, 16'(alert_out_n));
		hostVal = 16'($urandom_range(16'h6001, 16'h7fff));
		host_write(2, hostVal);
		chk("host temp", hostVal, railTemp[2]);
		wait_bits(2, 8'hc0);
		chk("peak", hostVal, peakTemp[2]);
		cyc(2000);
		chk("host kept", hostVal, railTemp[2]);
		host_write(2, 16'sh0100);
		chk("host newer", 16'h0100, railTemp[2]);
		cyc(10000);
		chk("avg temp", temp_of(8), railTemp[8]);
		chk("internal temp", linear_temp_sensor, railTemp[3]);
		railEnableCmd = '0;
		cyc(12 * MC);
		for (int r = 0; r < N; r++)
			clear_rail(r);
		cyc(4);
		chk("alert free", 16'h0001, 16'(alert_out_n));
		wrap_up();
	end
endmodule // rftm_monitor_core_bench
